// [rtl/phc_pkg.sv]
// constants for the powerline home control transmitter and receiver
// What this block does
// - receiver samples line data only at zero crossings
// - transmitter sends bits only at zero crossings
// - optional receive timeout counted in mains half-cycles
// - 16-bit result: site high byte, code low
// - 8-bit result: code only, site dropped
// - site codes 0 to 15 mean A to P
// - site code always sent, before unit/function code
// - unit address codes 0-15 select modules 1-16
// - unit address first, function after; all-functions alone
// - each command repeated, default and minimum two
// - five-bit codes: on 10010, off 11010, all-off 11100
// - all lights on 10100, all lights off 10000
// - brighten 10110, dim 11110
// - data pin driven as output while transmitting
// - data pin input while receiving; zero-cross always input
package phc_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int SITE_W = 4;
  localparam int UF_W = 5;
  localparam int START_W = 4;
  localparam int FRAME_W = START_W + SITE_W + UF_W;
  localparam logic [3:0] START_PAT = 4'he;
  localparam logic [3:0] FRAME_BITS = 4'hd;
  // idle crossings after the last repeat of a command
  localparam logic [3:0] GAP_HC = 4'h6;
  localparam logic [3:0] MIN_REPEAT = 4'h2;

  // ----------------------------------------------------------------
  // unit/function codes; codes below 16 are unit addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] UNIT_ON_CODE = 5'h12;
  localparam logic [4:0] UNIT_OFF_CODE = 5'h1a;
  localparam logic [4:0] ALL_UNITS_OFF_CODE = 5'h1c;
  localparam logic [4:0] ALL_LIGHTS_ON_CODE = 5'h14;
  localparam logic [4:0] ALL_LIGHTS_OFF_CODE = 5'h10;
  localparam logic [4:0] BRIGHT_CODE = 5'h16;
  localparam logic [4:0] DIM_CODE = 5'h1e;
  localparam int FUNC_BIT = 4;

  // ----------------------------------------------------------------
  // timing at the link clock
  // ----------------------------------------------------------------
  localparam int LINE_CLK_NS = 125;
  localparam int CARRIER_WIN_NS = 1000000;
  localparam int CARRIER_CYC = CARRIER_WIN_NS / LINE_CLK_NS;
  localparam int TMO_W = 16;

  // ----------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_GAP = 2'b10
  } phc_tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_WAIT = 2'b01
  } phc_rx_state_t;

endpackage

// [rtl/phc_line.sv]
// link-side logic: pin sampling, crossing detection, carrier window
`timescale 1ns/1ps
module phc_line #(
  parameter int unsigned CARRIER_CYC = 8000
) (
  input wire logic line_clk_i,
  input wire logic rstn_i,
  input wire logic zero_cross_pin_i,
  input wire logic line_data_i,
  input wire logic tx_req_tgl_i,
  input wire logic tx_bit_i,
  input wire logic tx_busy_i,
  output logic zc_tgl_o,
  output logic rx_bit_o,
  output logic line_data_o,
  output logic line_data_oe_n_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic zc_s1_q, zc_s2_q, zc_s3_q; // zero-cross pin, third stage for edge
  logic rd_s1_q, rd_s2_q; // receive data pin
  logic rq_s1_q, rq_s2_q, rq_s3_q, rq_s4_q; // transmit request toggle
  logic bz_s1_q, bz_s2_q; // transmitter busy level
  logic bt_s1_q, bt_s2_q; // transmit bit, steady around each request
  logic [15:0] win_q; // carrier window remaining

  // both pins are plain inputs here; the interface drives them open-collector
  always_ff @(posedge line_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      zc_s1_q <= 1'b1;
      zc_s2_q <= 1'b1;
      zc_s3_q <= 1'b1;
      rd_s1_q <= 1'b1;
      rd_s2_q <= 1'b1;
    end
    else
    begin
      zc_s1_q <= zero_cross_pin_i;
      zc_s2_q <= zc_s1_q;
      zc_s3_q <= zc_s2_q;
      rd_s1_q <= line_data_i;
      rd_s2_q <= rd_s1_q;
    end
  end

  // core-domain signals brought over
  always_ff @(posedge line_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rq_s1_q <= 1'b0;
      rq_s2_q <= 1'b0;
      rq_s3_q <= 1'b0;
      rq_s4_q <= 1'b0;
      bz_s1_q <= 1'b0;
      bz_s2_q <= 1'b0;
      bt_s1_q <= 1'b0;
      bt_s2_q <= 1'b0;
    end
    else
    begin
      rq_s1_q <= tx_req_tgl_i;
      rq_s2_q <= rq_s1_q;
      rq_s3_q <= rq_s2_q;
      rq_s4_q <= rq_s3_q;
      bz_s1_q <= tx_busy_i;
      bz_s2_q <= bz_s1_q;
      bt_s1_q <= tx_bit_i;
      bt_s2_q <= bt_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // crossing event: each pin edge is one half-cycle
  // ----------------------------------------------------------------
  // data is caught with the event so the core sees a held value
  always_ff @(posedge line_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      zc_tgl_o <= 1'b0;
      rx_bit_o <= 1'b0;
    end
    else if (zc_s2_q != zc_s3_q)
    begin
      zc_tgl_o <= ~zc_tgl_o;
      rx_bit_o <= rd_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // carrier window and pin direction
  // ----------------------------------------------------------------
  // a one bit opens a fixed window; losing busy cuts it short
  always_ff @(posedge line_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      win_q <= 16'h0000;
    end
    else if (!bz_s2_q)
    begin
      win_q <= 16'h0000;
    end
    else if ((rq_s3_q != rq_s4_q) && bt_s2_q)
    begin
      win_q <= 16'(CARRIER_CYC);
    end
    else if (win_q != 16'h0000)
    begin
      win_q <= win_q - 16'h0001;
    end
  end

  // output enable low only while the transmitter owns the pin
  always_ff @(posedge line_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      line_data_o <= 1'b0;
      line_data_oe_n_o <= 1'b1;
    end
    else
    begin
      line_data_o <= (win_q != 16'h0000) && bz_s2_q;
      line_data_oe_n_o <= ~bz_s2_q;
    end
  end

endmodule

// [rtl/phc_top.sv]
// powerline home control transmit and receive engines
`timescale 1ns/1ps
module phc_top #(
  parameter int unsigned CARRIER_CYC = phc_pkg::CARRIER_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic line_clk_i,
  // synchronous engine reset
  input wire logic sync_rst_i,
  // pins toward the line interface
  input wire logic zero_cross_pin_i,
  input wire logic line_data_i,
  output logic line_data_o,
  output logic line_data_oe_n_o,
  // transmit request
  input wire logic tx_valid_i,
  input wire logic [3:0] tx_site_i,
  input wire logic [4:0] tx_unit_function_i,
  input wire logic [3:0] tx_repeat_i,
  output logic tx_ready_o,
  output logic tx_done_o,
  // receive request
  input wire logic rx_start_i,
  input wire logic rx_byte_mode_i,
  input wire logic rx_timeout_en_i,
  input wire logic [15:0] rx_timeout_hc_i,
  output logic rx_busy_o,
  output logic rx_valid_o,
  output logic [15:0] rx_data_o,
  output logic rx_timeout_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic zc_tgl; // crossing toggle from the link side
  logic rx_bit; // line level held with that toggle
  logic zt_s1_q, zt_s2_q, zt_s3_q, zt_s4_q; // toggle synchroniser plus edge stages
  logic rb_s1_q, rb_s2_q; // held data bit synchroniser
  logic zc_ev; // one cycle per mains half-cycle
  phc_pkg::phc_tx_state_t tx_st_q; // transmit engine state
  logic [12:0] tx_sh_q; // frame bits, msb goes first
  logic [3:0] tx_bits_q; // bits left in this frame
  logic [3:0] tx_rep_q; // frames left, then gap crossings
  logic tx_req_tgl_q; // one flip per transmitted bit
  logic tx_bit_q; // bit being sent, steady until next crossing
  logic tx_busy_q; // transmitter owns the data pin
  logic [3:0] rep_eff; // requested repeats, clamped upward
  phc_pkg::phc_rx_state_t rx_st_q; // receive engine state
  logic [12:0] rx_sh_q; // last sampled bits
  logic [12:0] rx_next; // shift with the new bit
  logic rx_hit; // start pattern at the head of a full frame
  logic [15:0] tmo_q; // half-cycles waited so far
  logic rx_b8_q; // result width held for this wait
  logic rx_ten_q; // timeout enable held for this wait
  logic [15:0] rx_lim_q; // timeout limit held for this wait

  // ----------------------------------------------------------------
  // link-side logic on its own clock
  // ----------------------------------------------------------------
  phc_line #(
    .CARRIER_CYC(CARRIER_CYC)
  ) u_line (
    .line_clk_i(line_clk_i),
    .rstn_i(rstn_i),
    .zero_cross_pin_i(zero_cross_pin_i),
    .line_data_i(line_data_i),
    .tx_req_tgl_i(tx_req_tgl_q),
    .tx_bit_i(tx_bit_q),
    .tx_busy_i(tx_busy_q),
    .zc_tgl_o(zc_tgl),
    .rx_bit_o(rx_bit),
    .line_data_o(line_data_o),
    .line_data_oe_n_o(line_data_oe_n_o)
  );

  // ----------------------------------------------------------------
  // crossing events into the core clock
  // ----------------------------------------------------------------
  // the data bit moves with the toggle; taking the event one stage late
  // lets both settle even if their synchronisers resolve a cycle apart
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      zt_s1_q <= 1'b0;
      zt_s2_q <= 1'b0;
      zt_s3_q <= 1'b0;
      zt_s4_q <= 1'b0;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end
    else
    begin
      zt_s1_q <= zc_tgl;
      zt_s2_q <= zt_s1_q;
      zt_s3_q <= zt_s2_q;
      zt_s4_q <= zt_s3_q;
      rb_s1_q <= rx_bit;
      rb_s2_q <= rb_s1_q;
    end
  end

  // no edges on the pin means no events: both engines simply wait
  assign zc_ev = zt_s3_q ^ zt_s4_q;

  // ----------------------------------------------------------------
  // transmit engine
  // ----------------------------------------------------------------
  // zero or one repeats asked for still send two frames
  assign rep_eff = (tx_repeat_i < phc_pkg::MIN_REPEAT) ? phc_pkg::MIN_REPEAT
                                                       : tx_repeat_i;

  // state, frame shifter and repeat counting
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_st_q <= phc_pkg::TX_IDLE;
      tx_sh_q <= 13'h0000;
      tx_bits_q <= 4'h0;
      tx_rep_q <= 4'h0;
      tx_req_tgl_q <= 1'b0;
      tx_bit_q <= 1'b0;
    end
    else if (sync_rst_i)
    begin
      tx_st_q <= phc_pkg::TX_IDLE;
      tx_bits_q <= 4'h0;
      tx_rep_q <= 4'h0;
      tx_bit_q <= 1'b0;
    end
    else
    begin
      case (tx_st_q)
        phc_pkg::TX_IDLE:
        begin
          // a unit address and a function are two separate requests;
          // all-module functions may be requested on their own
          if (tx_valid_i)
          begin
            // start pattern, then site, then unit/function code
            tx_sh_q <= {phc_pkg::START_PAT, tx_site_i,
                        tx_unit_function_i};
            tx_bits_q <= phc_pkg::FRAME_BITS;
            tx_rep_q <= rep_eff;
            tx_st_q <= phc_pkg::TX_SEND;
          end
        end
        phc_pkg::TX_SEND:
        begin
          // one bit per crossing, never between crossings
          if (zc_ev)
          begin
            tx_bit_q <= tx_sh_q[12];
            tx_req_tgl_q <= ~tx_req_tgl_q;
            tx_sh_q <= {tx_sh_q[11:0], tx_sh_q[12]};
            if (tx_bits_q == 4'h1)
            begin
              // rotation restored the frame, ready to repeat it
              tx_bits_q <= phc_pkg::FRAME_BITS;
              tx_rep_q <= tx_rep_q - 4'h1;
              if (tx_rep_q == 4'h1)
              begin
                tx_rep_q <= phc_pkg::GAP_HC;
                tx_st_q <= phc_pkg::TX_GAP;
              end
            end
            else
            begin
              tx_bits_q <= tx_bits_q - 4'h1;
            end
          end
        end
        phc_pkg::TX_GAP:
        begin
          // silent crossings keep the next command apart
          if (zc_ev)
          begin
            tx_bit_q <= 1'b0;
            tx_req_tgl_q <= ~tx_req_tgl_q;
            tx_rep_q <= tx_rep_q - 4'h1;
            if (tx_rep_q == 4'h1)
            begin
              tx_st_q <= phc_pkg::TX_IDLE;
            end
          end
        end
        default:
        begin
          tx_st_q <= phc_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // handshake outputs and pin ownership
  // the pin stays driven through the gap so the last window finishes
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_ready_o <= 1'b0;
      tx_done_o <= 1'b0;
      tx_busy_q <= 1'b0;
    end
    else
    begin
      tx_ready_o <= (tx_st_q == phc_pkg::TX_IDLE) && !tx_valid_i
                    && !sync_rst_i;
      tx_done_o <= (tx_st_q == phc_pkg::TX_GAP) && zc_ev
                   && (tx_rep_q == 4'h1) && !sync_rst_i;
      tx_busy_q <= !sync_rst_i
                   && ((tx_st_q != phc_pkg::TX_IDLE)
                       || tx_valid_i);
    end
  end

  // ----------------------------------------------------------------
  // receive engine
  // ----------------------------------------------------------------
  // newest bit enters at the bottom; the start pattern sits on top
  assign rx_next = {rx_sh_q[11:0], rb_s2_q};
  assign rx_hit = (rx_next[12:9] == phc_pkg::START_PAT);

  // arm, wait, finish on a frame or on the timeout
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rx_st_q <= phc_pkg::RX_IDLE;
      rx_sh_q <= 13'h0000;
      tmo_q <= 16'h0000;
      rx_b8_q <= 1'b0;
      rx_ten_q <= 1'b0;
      rx_lim_q <= 16'h0000;
    end
    else if (sync_rst_i)
    begin
      rx_st_q <= phc_pkg::RX_IDLE;
      tmo_q <= 16'h0000;
      rx_sh_q <= 13'h0000;
    end
    else
    begin
      case (rx_st_q)
        phc_pkg::RX_IDLE:
        begin
          if (rx_start_i)
          begin
            // options are held so a change mid-wait has no effect
            rx_st_q <= phc_pkg::RX_WAIT;
            rx_sh_q <= 13'h0000;
            tmo_q <= 16'h0000;
            rx_b8_q <= rx_byte_mode_i;
            rx_ten_q <= rx_timeout_en_i;
            rx_lim_q <= rx_timeout_hc_i;
          end
        end
        phc_pkg::RX_WAIT:
        begin
          // the line is looked at only on a crossing event
          if (zc_ev)
          begin
            rx_sh_q <= rx_next;
            tmo_q <= tmo_q + 16'h0001;
            if (rx_hit)
            begin
              rx_st_q <= phc_pkg::RX_IDLE;
            end
            else if (rx_ten_q && (tmo_q + 16'h0001 >= rx_lim_q))
            begin
              rx_st_q <= phc_pkg::RX_IDLE;
            end
          end
        end
        default:
        begin
          rx_st_q <= phc_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // result and outcome strobes; a frame beats a timeout on one crossing
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rx_valid_o <= 1'b0;
      rx_timeout_o <= 1'b0;
      rx_data_o <= 16'h0000;
      rx_busy_o <= 1'b0;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      rx_timeout_o <= 1'b0;
      rx_busy_o <= (rx_st_q == phc_pkg::RX_WAIT) && !sync_rst_i;
      if (!sync_rst_i && (rx_st_q == phc_pkg::RX_WAIT) && zc_ev)
      begin
        if (rx_hit)
        begin
          rx_valid_o <= 1'b1;
          if (rx_b8_q)
          begin
            // byte result keeps only the unit/function code
            rx_data_o <= {8'h00, 3'h0, rx_next[4:0]};
          end
          else
          begin
            // word result: site high, unit/function low
            rx_data_o <= {4'h0, rx_next[8:5], 3'h0, rx_next[4:0]};
          end
        end
        else if (rx_ten_q && (tmo_q + 16'h0001 >= rx_lim_q))
        begin
          rx_timeout_o <= 1'b1;
        end
      end
    end
  end

endmodule

// [testbench/phc_line_model.sv]
// behavioural model of the line interface with its zero-cross output
`timescale 1ns/1ps
module phc_line_model (
  input wire logic line_clk_i,
  input wire logic run_i,
  input wire logic send_i,
  input wire logic [12:0] frame_i,
  input wire logic tx_data_i,
  output logic zero_cross_o,
  output logic line_rx_o,
  output logic bit_stb_o,
  output logic bit_o,
  output logic play_busy_o
);
  localparam int HALF = 16; // link cycles per shortened half-cycle
  int ph = 0;
  int left = 0;
  logic [12:0] sh = 13'h0;
  logic seen = 1'b0;
  initial
  begin
    zero_cross_o = 1'b1; // pull-up level
    line_rx_o = 1'b0;
    bit_stb_o = 1'b0;
    bit_o = 1'b0;
    play_busy_o = 1'b0;
  end
  // ------------------------------------------------------------
  // crossings stand still while run_i is low, as a dead mains would
  // ------------------------------------------------------------
  always @(posedge line_clk_i)
  begin
    bit_stb_o <= 1'b0;
    if (tx_data_i)
      seen <= 1'b1;
    if (run_i)
    begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      if (ph == HALF - 1)
      begin
        // one crossing ends a half-cycle; report carrier seen in it
        zero_cross_o <= ~zero_cross_o;
        bit_stb_o <= 1'b1;
        bit_o <= seen | tx_data_i;
        seen <= 1'b0;
      end
      if (ph == HALF / 2)
      begin
        // receive data moves mid half-cycle, well clear of the crossing
        if (left > 0)
        begin
          line_rx_o <= sh[12];
          sh <= sh << 1;
          left <= left - 1;
        end
        else if (send_i && !play_busy_o)
        begin
          line_rx_o <= frame_i[12];
          sh <= frame_i << 1;
          left <= 12;
          play_busy_o <= 1'b1;
        end
        else
        begin
          // no carrier between frames
          line_rx_o <= 1'b0;
          play_busy_o <= 1'b0;
        end
      end
    end
  end
endmodule

// [testbench/phc_top_asserts.sv]
// concurrent checks on the ports of the powerline control top
`timescale 1ns/1ps
module phc_top_asserts #(
  parameter int unsigned CARRIER_CYC = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic line_clk_i,
  input wire logic sync_rst_i,
  input wire logic line_data_o,
  input wire logic line_data_oe_n_o,
  input wire logic tx_valid_i,
  input wire logic tx_ready_o,
  input wire logic tx_done_o,
  input wire logic rx_start_i,
  input wire logic rx_byte_mode_i,
  input wire logic rx_timeout_en_i,
  input wire logic rx_busy_o,
  input wire logic rx_valid_o,
  input wire logic [15:0] rx_data_o,
  input wire logic rx_timeout_o
);
  // ------------------------------------------------------------
  // length of the present carrier burst in link cycles
  // ------------------------------------------------------------
  int unsigned run_q;
  always_ff @(posedge line_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      run_q <= 0;
    else
      run_q <= line_data_o ? run_q + 1 : 0;
  end
  done_pulse_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) tx_done_o |=> !tx_done_o)
    else $error("tx done longer than one cycle");
  frame_pulse_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) rx_valid_o |=> !rx_valid_o)
    else $error("rx valid longer than one cycle");
  tmo_pulse_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) rx_timeout_o |=> !rx_timeout_o)
    else $error("timeout longer than one cycle");
  tx_take_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    tx_ready_o && tx_valid_i && !sync_rst_i |=> !tx_ready_o)
    else $error("request not taken");
  rx_arm_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    rx_start_i && !rx_busy_o && !sync_rst_i |=> ##1 rx_busy_o)
    else $error("receiver not armed");
  frame_wins_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) rx_valid_o |-> !rx_timeout_o)
    else $error("timeout beside a frame");
  tmo_enable_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) rx_timeout_o |-> rx_timeout_en_i)
    else $error("timeout while disabled");
  word_place_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i) rx_valid_o && !rx_byte_mode_i
    |-> rx_data_o[15:12] == 4'h0 && rx_data_o[7:5] == 3'h0)
    else $error("word result misplaced");
  byte_place_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    rx_valid_o && rx_byte_mode_i |-> rx_data_o[15:5] == 11'h0)
    else $error("byte result holds site");
  sync_idle_a: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    sync_rst_i |=> !rx_busy_o && !tx_done_o && !rx_valid_o)
    else $error("engine busy after sync reset");
  drive_oe_a: assert property (
    @(posedge line_clk_i) disable iff (!rstn_i) line_data_o |-> !line_data_oe_n_o)
    else $error("carrier while pin released");
  carrier_len_a: assert property (
    @(posedge line_clk_i) disable iff (!rstn_i) $fell(line_data_o) |-> run_q == CARRIER_CYC)
    else $error("carrier window wrong length");
endmodule
bind phc_top phc_top_asserts #(.CARRIER_CYC(CARRIER_CYC)) i_phc_top_asserts (
  .clk_i(clk_i), .rstn_i(rstn_i), .line_clk_i(line_clk_i), .sync_rst_i(sync_rst_i),
  .line_data_o(line_data_o), .line_data_oe_n_o(line_data_oe_n_o),
  .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_done_o(tx_done_o),
  .rx_start_i(rx_start_i), .rx_byte_mode_i(rx_byte_mode_i),
  .rx_timeout_en_i(rx_timeout_en_i), .rx_busy_o(rx_busy_o), .rx_valid_o(rx_valid_o),
  .rx_data_o(rx_data_o), .rx_timeout_o(rx_timeout_o));

// [testbench/powerline_home_control_txrx_bench.sv]
// self-checking bench for the powerline control transmitter and receiver
`timescale 1ns/1ps
module powerline_home_control_txrx_bench;
  logic clk = 0, rstn = 0, lclk = 0, sync_rst = 0, zc, lrx, ldo, loe_n;
  logic tx_valid = 0, tx_ready, tx_done, rx_start = 0, rx_byte = 0, rx_ten = 0;
  logic [3:0] tx_site = 4'h0, tx_rep = 4'h0;
  logic [4:0] tx_uf = 5'h0;
  logic [15:0] rx_thc = 16'h0, rx_data;
  logic rx_busy, rx_valid, rx_tmo, run = 0, send = 0, bstb, bitv, pbusy, skip = 0;
  logic [12:0] frame = 13'h0;
  logic exp_bits[$];
  logic [16:0] exp_rx[$];
  int n_mismatch = 0, tests_run = 0;
  // shortened carrier window fits inside the model's 16-cycle half-cycle in simulation
  phc_top #(.CARRIER_CYC(4)) i_phc_top (.clk_i(clk), .rstn_i(rstn), .line_clk_i(lclk),
    .sync_rst_i(sync_rst), .zero_cross_pin_i(zc), .line_data_i(lrx), .line_data_o(ldo),
    .line_data_oe_n_o(loe_n), .tx_valid_i(tx_valid), .tx_site_i(tx_site),
    .tx_unit_function_i(tx_uf), .tx_repeat_i(tx_rep), .tx_ready_o(tx_ready),
    .tx_done_o(tx_done), .rx_start_i(rx_start), .rx_byte_mode_i(rx_byte),
    .rx_timeout_en_i(rx_ten), .rx_timeout_hc_i(rx_thc), .rx_busy_o(rx_busy),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_timeout_o(rx_tmo));
  phc_line_model i_phc_line_model (.line_clk_i(lclk), .run_i(run), .send_i(send),
    .frame_i(frame), .tx_data_i(ldo), .zero_cross_o(zc), .line_rx_o(lrx),
    .bit_stb_o(bstb), .bit_o(bitv), .play_busy_o(pbusy));
  always #5 clk = ~clk;
  // link clock of 125 ns, offset so its edges never line up with clk
  initial
  begin
    #7.3;
    forever #62.5 lclk = ~lclk;
  end
  // ------------------------------------------------------------
  // compare tasks and bus tasks
  // ------------------------------------------------------------
  task automatic chk_bit(input string w, input logic e, input logic s);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", w, e, s);
    end
  endtask
  task automatic chk_word(input string w, input logic [16:0] e, input logic [16:0] s);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one command: note the expected line bits, request, wait for done
  task automatic send_cmd(input logic [3:0] s, input logic [4:0] u, input logic [3:0] r);
    logic [12:0] f;
    int n;
    int k;
    f = {4'he, s, u};
    n = (r < 4'h2) ? 2 : int'(r);
    for (int j = 0; j < n; j++)
      for (k = 12; k >= 0; k--)
        exp_bits.push_back(f[k]);
    skip = 1'b1;
    @(posedge clk);
    tx_site <= s;
    tx_uf <= u;
    tx_rep <= r;
    tx_valid <= 1'b1;
    for (k = 0; k < 100 && tx_ready !== 1'b0; k++) @(negedge clk);
    @(posedge clk);
    tx_valid <= 1'b0;
    for (k = 0; k < 40000 && tx_done !== 1'b1; k++) @(negedge clk);
    chk_bit("tx done", 1'b1, tx_done);
    chk_bit("tx bits all sent", 1'b1, exp_bits.size() == 0);
    repeat (60) @(negedge clk);
    chk_bit("tx pin released", 1'b1, loe_n);
  endtask
  // one receive: arm, let the model play a frame, wait for the answer
  task automatic recv(input logic b, input logic t, input logic [15:0] h,
                      input logic [12:0] f, input logic [16:0] e);
    int k;
    exp_rx.push_back(e);
    @(posedge clk);
    rx_byte <= b;
    rx_ten <= t;
    rx_thc <= h;
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
    send <= f[12];
    frame <= f;
    for (k = 0; k < 400 && f[12] && pbusy !== 1'b1; k++) @(negedge clk);
    @(posedge clk);
    send <= 1'b0;
    for (k = 0; k < 30000 && exp_rx.size() != 0; k++) @(negedge clk);
    chk_bit("rx answered", 1'b1, exp_rx.size() == 0);
    exp_rx.delete();
    for (k = 0; k < 5000 && pbusy !== 1'b0; k++) @(negedge clk);
  endtask
  // ------------------------------------------------------------
  // result watchers: oldest note against what appears
  // ------------------------------------------------------------
  always @(negedge lclk)
  begin
    if (bstb === 1'b1)
    begin
      if (exp_bits.size() == 0)
        chk_bit("idle line bit", 1'b0, bitv);
      else if (!(skip && bitv === 1'b0))
      begin
        skip = 1'b0;
        chk_bit("tx line bit", exp_bits.pop_front(), bitv);
      end
    end
  end
  always @(negedge clk)
  begin
    if (rx_valid === 1'b1 || rx_tmo === 1'b1)
    begin
      if (exp_rx.size() == 0)
        chk_bit("rx spare result", 1'b0, 1'b1);
      else
        chk_word("rx result", exp_rx.pop_front(), {rx_tmo, rx_valid ? rx_data : 16'h0});
    end
  end
  initial
  begin
    repeat (90000) @(negedge clk);
    n_mismatch++;
    $display("[FAIL] watchdog expected finish seen hang");
    conclude();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [4:0] codes[8];
    logic [3:0] s;
    codes = '{5'h12, 5'h1a, 5'h1c, 5'h14, 5'h10, 5'h16, 5'h1e, 5'h0f};
    void'($urandom(32'heff611f6));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(negedge clk);
    chk_bit("reset ready", 1'b1, tx_ready);
    chk_bit("reset pin released", 1'b1, loe_n);
    $display("test reset done");
    @(posedge clk);
    rx_ten <= 1'b1;
    rx_thc <= 16'h1;
    rx_start <= 1'b1;
    @(posedge clk);
    rx_start <= 1'b0;
    repeat (2000) @(negedge clk);
    chk_bit("rx waits without crossings", 1'b1, rx_busy);
    @(posedge clk);
    sync_rst <= 1'b1;
    @(posedge clk);
    sync_rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk_bit("rx idle after sync reset", 1'b0, rx_busy);
    $display("test receive stall done");
    fork
      begin
        repeat (3000) @(negedge clk);
        chk_bit("tx stalled ready", 1'b0, tx_ready);
        chk_bit("tx stalled data", 1'b0, ldo);
        chk_bit("tx pin driven", 1'b0, loe_n);
        @(posedge clk);
        run <= 1'b1;
      end
    join_none
    for (int i = 0; i < 8; i++)
    begin
      s = 4'($urandom);
      send_cmd(s, (i == 6) ? 5'($urandom_range(0, 15)) : codes[i], 4'(i % 4));
      $display("test transmit %0d done", i);
    end
    s = 4'($urandom);
    recv(1'b0, 1'b0, 16'h0, {4'he, s, 5'h16}, {1'b0, 4'h0, s, 8'h16});
    recv(1'b1, 1'b1, 16'h40, {4'he, s, 5'h0b}, {1'b0, 16'h000b});
    recv(1'b0, 1'b1, 16'h3, 13'h0, {1'b1, 16'h0});
    $display("test receive done");
    conclude();
  end
endmodule
